// File: logic/lcr_defines.svh
`ifndef LCR_DEFINES_SVH
`define LCR_DEFINES_SVH
// register offsets
`define LCR_CUR_WR_LO 16'h001c
`define LCR_CUR_WR_HI 16'h001d
`define LCR_CUR_RD_LO 16'h001e
`define LCR_CUR_RD_HI 16'h801f
`define LCR_DEPTH 16'h8020
`define LCR_PROD_ID 16'h0030
`define LCR_PLL_DIV 16'h0031
`define LCR_PLL_FILT 16'h8032
`define LCR_PLL_VCO 16'h0033
`define LCR_PANEL 16'h0034
`define LCR_MEM_DATA 16'h0040
`define LCR_PAL_BASE 16'h8063
`define LCR_PAL_LAST 16'h8072
`define LCR_CHAR_SIZE 16'h8001
`define LCR_PIX_SCROLL 16'h801b
// reset values
`define LCR_DEPTH_RST 2'h0
`define LCR_PLL_DIV_RST 8'he1
`define LCR_PLL_FILT_RST 8'h99
`define LCR_PLL_VCO_RST 8'h24
`define LCR_PANEL_RST 8'h24
// panel and VCO control field positions
`define LCR_PNL_EN 0
`define LCR_PNL_COLOR 1
`define LCR_PNL_SCALER 2
`define LCR_PNL_RSV 3
`define LCR_PNL_SHIFT_POL 4
`define LCR_PNL_DE_POL 5
`define LCR_PNL_LINE_POL 6
`define LCR_PNL_FRAME_POL 7
`define LCR_VCO_RSV 7
// values the host must program
`define LCR_CHAR_SIZE_VAL 8'h07
`define LCR_FILT_LOW 4'h9
`define LCR_FILT_MID 4'h7
`define LCR_FILT_HIGH 4'h5
`define LCR_PIR_MAX 4'hb
// frequency limits in kHz
`define LCR_FIN_MID_KHZ 20000
`define LCR_FIN_HIGH_KHZ 50000
`define LCR_FIN_MIN_KHZ 5000
`define LCR_FIN_MAX_KHZ 66000
`define LCR_FOUT_MIN_KHZ 20000
`define LCR_FOUT_MAX_KHZ 110000
`define LCR_VCO_MIN_KHZ 100000
`define LCR_VCO_MAX_KHZ 400000
`define LCR_FP_MIN_KHZ 2000
`define LCR_FP_MAX_KHZ 35000
// clock
`define LCR_CLK_PERIOD_NS 25
`define LCR_NS_PER_MS 1000000
`endif

// File: logic/lcr_pkg.sv
package lcr_pkg;
   // host command codes
   typedef enum logic [2:0] {
      LCR_OP_CUR_WR, LCR_OP_CUR_RD, LCR_OP_MEM_WR, LCR_OP_MEM_RD,
      LCR_OP_DEPTH, LCR_OP_PANEL, LCR_OP_PLL, LCR_OP_ID
   } lcr_op_type;
   // host sequencer states
   typedef enum logic [1:0] {
      LCR_IDLE, LCR_RUN, LCR_DONE
   } lcr_host_state_type;
endpackage : lcr_pkg

// File: logic/lcr_bus_if.sv
`timescale 1ns/1ps
interface lcr_bus_if;
   logic [15:0] addr;
   logic [7:0] wrData;
   logic wrStb;
   logic rdStb;
   logic [7:0] rdData;
   modport device (input addr, input wrData, input wrStb, input rdStb,
      output rdData);
   modport host (output addr, output wrData, output wrStb,
      output rdStb, input rdData);
endinterface : lcr_bus_if

// File: logic/lcr_device.sv
// Behaviour
// - cursor address steers memory reads and writes
// - cursor changes by cursor write or increment
// - accesses continue from last address plus increments
// - cursor read: low byte, then high byte
// - depth code 00/01/10 gives 1/2/4 bpp
// - host forces depth 00 in text mode
// - host sets char size 7, scroll 0 unless depth code is 00
// - all layers share one pixel depth
// - read-only product code, writes ignored
// - host leaves panel config alone while displaying
// - pixel clock is PLL out over field+1
// - PLL input is system clock over field+1
// - PLL multiplier is field plus one
// - VCO factor 2/4/8, code 00 reserved
// - host picks filter from PLL input frequency
// - host picks VCO range from VCO band
// - host keeps clocks inside their limits
// - host keeps reserved bits zero
// - gray 1bpp drives LLLL or HHHH
// - gray 2bpp drives LLLL/LHLH/HLHL/HHHH
// - colour mode drives palette entry per pixel
// - enable bit selects TFT over STN
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "lcr_defines.svh"
module lcr_device
   import lcr_pkg::*;
#(
   parameter logic [7:0] PRODUCT_ID = 8'ha5, // arbitrary value
   parameter int HACT = 320,
   parameter int VACT = 240,
   parameter int HTOT = 400,
   parameter int VTOT = 262,
   parameter int HPW = 8,
   parameter int VPW = 2
) (
   input wire logic clk,
   input wire logic rst_b,
   lcr_bus_if.device bus,
   output logic pixelClockOut,
   output logic frameSyncOut,
   output logic lineSyncOut,
   output logic dataEnableOut,
   output logic [5:0] panelDataOut,
   output logic [4:0] inputDivideRatio,
   output logic [4:0] pllMultiplier,
   output logic [3:0] vcoFactor,
   output logic [4:0] outputDivideRatio,
   output logic [3:0] pllFilterField,
   output logic [4:0] vcoRangeField,
   output logic scalerNearest,
   output logic panelEnabled
);
   localparam int CW = 11;
   if (HACT >= HTOT || VACT >= VTOT || HTOT > 2047 || VTOT > 2047
      || HPW >= HTOT || VPW >= VTOT) begin : g_bad_timing
      $error("lcr_device: unusable panel timing parameters");
   end

   ////////////////////////////////////////////////////////////////////
   // registers and state
   logic [7:0] mem [0:32767];
   logic [14:0] cursor_q, cursor_d;
   logic [7:0] curLo_q, curLo_d;
   logic [6:0] curHiHold_q, curHiHold_d;
   logic [1:0] depth_q, depth_d;
   logic [7:0] pllDiv_q, pllDiv_d;
   logic [7:0] pllFilt_q, pllFilt_d;
   logic [7:0] pllVco_q, pllVco_d;
   logic [7:0] panel_q, panel_d;
   logic [5:0] pal_q [0:15];
   logic [5:0] pal_d [0:15];
   logic [7:0] rdData_q, rdData_d;
   logic memWr;
   logic [15:0] palOff;

   assign palOff = bus.addr - `LCR_PAL_BASE;

   // register writes, reads and cursor movement
   always_comb begin
      cursor_d = cursor_q;
      curLo_d = curLo_q;
      curHiHold_d = curHiHold_q;
      depth_d = depth_q;
      pllDiv_d = pllDiv_q;
      pllFilt_d = pllFilt_q;
      pllVco_d = pllVco_q;
      panel_d = panel_q;
      pal_d = pal_q;
      rdData_d = 8'h00;
      memWr = 1'b0;
      if (bus.wrStb) begin
         case (bus.addr)
            `LCR_CUR_WR_LO: curLo_d = bus.wrData;
            `LCR_CUR_WR_HI: cursor_d = {bus.wrData[6:0], curLo_q};
            `LCR_DEPTH: depth_d = bus.wrData[1:0];
            `LCR_PLL_DIV: pllDiv_d = bus.wrData;
            `LCR_PLL_FILT: pllFilt_d = bus.wrData;
            `LCR_PLL_VCO: pllVco_d = bus.wrData;
            `LCR_PANEL: panel_d = bus.wrData;
            `LCR_MEM_DATA: begin
               memWr = 1'b1;
               cursor_d = cursor_q + 15'h0001;
            end
            default: begin
               if (bus.addr >= `LCR_PAL_BASE && bus.addr <= `LCR_PAL_LAST)
                  pal_d[palOff[3:0]] = bus.wrData[5:0];
            end
         endcase
      end else if (bus.rdStb) begin
         case (bus.addr)
            `LCR_CUR_RD_LO: begin
               rdData_d = cursor_q[7:0];
               curHiHold_d = cursor_q[14:8];
            end
            `LCR_CUR_RD_HI: rdData_d = {1'b0, curHiHold_q};
            `LCR_DEPTH: rdData_d = {6'h00, depth_q};
            `LCR_PROD_ID: rdData_d = PRODUCT_ID;
            `LCR_PLL_DIV: rdData_d = pllDiv_q;
            `LCR_PLL_FILT: rdData_d = pllFilt_q;
            `LCR_PLL_VCO: rdData_d = pllVco_q;
            `LCR_PANEL: rdData_d = panel_q;
            `LCR_MEM_DATA: begin
               rdData_d = mem[cursor_q];
               cursor_d = cursor_q + 15'h0001;
            end
            default: begin
               if (bus.addr >= `LCR_PAL_BASE && bus.addr <= `LCR_PAL_LAST)
                  rdData_d = {2'b00, pal_q[palOff[3:0]]};
            end
         endcase
      end
   end

   // register bank flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cursor_q <= 15'h0000;
         curLo_q <= 8'h00;
         curHiHold_q <= 7'h00;
         depth_q <= `LCR_DEPTH_RST;
         pllDiv_q <= `LCR_PLL_DIV_RST;
         pllFilt_q <= `LCR_PLL_FILT_RST;
         pllVco_q <= `LCR_PLL_VCO_RST;
         panel_q <= `LCR_PANEL_RST;
         rdData_q <= 8'h00;
         for (int i = 0; i < 16; i++) begin
            pal_q[i] <= 6'h00;
         end
      end else begin
         cursor_q <= cursor_d;
         curLo_q <= curLo_d;
         curHiHold_q <= curHiHold_d;
         depth_q <= depth_d;
         pllDiv_q <= pllDiv_d;
         pllFilt_q <= pllFilt_d;
         pllVco_q <= pllVco_d;
         panel_q <= panel_d;
         rdData_q <= rdData_d;
         pal_q <= pal_d;
      end
   end

   // display memory write port
   always_ff @(posedge clk) begin
      if (memWr) begin
         mem[cursor_q] <= bus.wrData;
      end
   end

   assign bus.rdData = rdData_q;

   ////////////////////////////////////////////////////////////////////
   // panel scan
   logic [3:0] divCnt_q, divCnt_d;
   logic [CW-1:0] hCnt_q, hCnt_d, vCnt_q, vCnt_d;
   logic pixClk_q, pixClk_d, frame_q, frame_d, line_q, line_d;
   logic de_q, de_d;
   logic [5:0] data_q, data_d;
   logic pixEn, tftOn, active;
   logic [21:0] pixIdx;
   logic [23:0] bitOff;
   logic [7:0] shifted;
   logic [3:0] pixVal, gray;

   assign tftOn = panel_q[`LCR_PNL_EN];
   assign pixEn = tftOn && divCnt_q == pllDiv_q[7:4];

   // pixel fetch; one depth code serves every layer
   always_comb begin
      pixIdx = 22'(vCnt_q * HACT) + 22'(hCnt_q);
      bitOff = {2'b00, pixIdx} << depth_q;
      if (depth_q == 2'b11) bitOff = {2'b00, pixIdx};
      shifted = mem[bitOff[17:3]] << bitOff[2:0];
      case (depth_q)
         2'b01: pixVal = {2'b00, shifted[7:6]};
         2'b10: pixVal = shifted[7:4];
         default: pixVal = {3'b000, shifted[7]};
      endcase
      case (depth_q)
         2'b01: gray = {pixVal[1:0], pixVal[1:0]};
         2'b10: gray = pixVal;
         default: gray = {4{pixVal[0]}};
      endcase
   end

   // counters, syncs and pixel data
   always_comb begin
      divCnt_d = pixEn || !tftOn ? 4'h0 : divCnt_q + 4'h1;
      hCnt_d = hCnt_q;
      vCnt_d = vCnt_q;
      data_d = data_q;
      if (!tftOn) begin
         hCnt_d = '0;
         vCnt_d = '0;
      end else if (pixEn) begin
         if (hCnt_q == CW'(HTOT - 1)) begin
            hCnt_d = '0;
            vCnt_d = vCnt_q == CW'(VTOT - 1) ? '0 : vCnt_q + 1'b1;
         end else begin
            hCnt_d = hCnt_q + 1'b1;
         end
      end
      active = tftOn && hCnt_q < CW'(HACT) && vCnt_q < CW'(VACT);
      if (pixEn) begin
         if (!active) data_d = 6'h00;
         else if (panel_q[`LCR_PNL_COLOR]) data_d = pal_q[pixVal];
         else data_d = {2'b00, gray};
      end
      // an asserted sync or data enable equals its polarity bit; the pixel clock phase is its inverse
      de_d = active == panel_q[`LCR_PNL_DE_POL];
      line_d = (tftOn && hCnt_q < CW'(HPW)) == panel_q[`LCR_PNL_LINE_POL];
      frame_d = (tftOn && vCnt_q < CW'(VPW)) ==
         panel_q[`LCR_PNL_FRAME_POL];
      pixClk_d = tftOn && (divCnt_d <= {1'b0, pllDiv_q[7:5]}) !=
         panel_q[`LCR_PNL_SHIFT_POL];
   end

   // scan flops and PLL control outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         divCnt_q <= 4'h0;
         hCnt_q <= '0;
         vCnt_q <= '0;
         data_q <= 6'h00;
         pixClk_q <= 1'b0;
         // inactive levels of the reset polarities
         frame_q <= 1'b1;
         line_q <= 1'b1;
         de_q <= 1'b0;
         inputDivideRatio <= 5'h00;
         pllMultiplier <= 5'h00;
         vcoFactor <= 4'h0;
         outputDivideRatio <= 5'h00;
         pllFilterField <= 4'h0;
         vcoRangeField <= 5'h00;
         scalerNearest <= 1'b0;
         panelEnabled <= 1'b0;
      end else begin
         divCnt_q <= divCnt_d;
         hCnt_q <= hCnt_d;
         vCnt_q <= vCnt_d;
         data_q <= data_d;
         pixClk_q <= pixClk_d;
         frame_q <= frame_d;
         line_q <= line_d;
         de_q <= de_d;
         // reserved input codes give ratio 0
         inputDivideRatio <= pllDiv_q[3:0] > `LCR_PIR_MAX ? 5'h00 :
            {1'b0, pllDiv_q[3:0]} + 5'h01;
         pllMultiplier <= {1'b0, pllFilt_q[3:0]} + 5'h01;
         vcoFactor <= pllVco_q[6:5] == 2'b00 ? 4'h0 :
            4'h1 << pllVco_q[6:5];
         outputDivideRatio <= {1'b0, pllDiv_q[7:4]} + 5'h01;
         pllFilterField <= pllFilt_q[7:4];
         vcoRangeField <= pllVco_q[4:0];
         scalerNearest <= panel_q[`LCR_PNL_SCALER];
         panelEnabled <= tftOn;
      end
   end

   assign pixelClockOut = pixClk_q;
   assign frameSyncOut = frame_q;
   assign lineSyncOut = line_q;
   assign dataEnableOut = de_q;
   assign panelDataOut = data_q;
endmodule : lcr_device

// File: logic/lcr_host.sv
`timescale 1ns/1ps
`include "lcr_defines.svh"
module lcr_host
   import lcr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   lcr_bus_if.host bus,
   input wire logic cmdValid,
   input wire lcr_op_type cmdOp,
   input wire logic [15:0] cmdData,
   input wire logic textMode,
   input wire logic displayOn,
   output logic busy,
   output logic rspValid,
   output logic rspErr,
   output logic [15:0] rspData
);
   localparam int SYS_KHZ = `LCR_NS_PER_MS / `LCR_CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////
   // VCO band to range code
   function automatic logic [4:0] vcoRange(input logic [31:0] f);
      if (f < 110000) return 5'h01;
      else if (f < 145000) return 5'h02;
      else if (f < 180000) return 5'h03;
      else if (f < 215000) return 5'h04;
      else if (f < 250000) return 5'h05;
      else if (f < 285000) return 5'h06;
      else if (f < 320000) return 5'h07;
      else if (f < 350000) return 5'h09;
      else if (f < 375000) return 5'h0b;
      else return 5'h0c;
   endfunction : vcoRange

   lcr_host_state_type state_q, state_d;
   lcr_op_type op_q, op_d;
   logic [15:0] arg_q, arg_d, rsp_q, rsp_d;
   logic [1:0] step_q, step_d;
   logic rdPend_q, rdPend_d, capHi_q, capHi_d, err_q, err_d;
   logic busy_q, rspValid_q;
   logic panelOn_q, panelOn_d;
   logic [15:0] addr_q, addr_d;
   logic [7:0] wd_q, wd_d;
   logic wr_q, wr_d, rd_q, rd_d;
   logic [15:0] sAddr;
   logic [7:0] sData;
   logic sRd, sLast, bad;
   logic [31:0] fin, fout, fvco, fp;
   logic [3:0] filt;

   // PLL frequency plan and limits
   always_comb begin
      fin = SYS_KHZ / ({28'h0, arg_q[3:0]} + 32'h1);
      fout = fin * ({28'h0, arg_q[11:8]} + 32'h1);
      fvco = fout << arg_q[13:12];
      fp = fout / ({28'h0, arg_q[7:4]} + 32'h1);
      filt = fin < `LCR_FIN_MID_KHZ ? `LCR_FILT_LOW :
         fin < `LCR_FIN_HIGH_KHZ ? `LCR_FILT_MID : `LCR_FILT_HIGH;
      bad = arg_q[3:0] > `LCR_PIR_MAX || arg_q[13:12] == 2'b00 ||
         fin < `LCR_FIN_MIN_KHZ || fin > `LCR_FIN_MAX_KHZ ||
         fout < `LCR_FOUT_MIN_KHZ || fout > `LCR_FOUT_MAX_KHZ ||
         fvco < `LCR_VCO_MIN_KHZ || fvco > `LCR_VCO_MAX_KHZ ||
         fp < `LCR_FP_MIN_KHZ || fp > `LCR_FP_MAX_KHZ;
   end

   // access sequence of each command
   always_comb begin
      sAddr = 16'h0000;
      sData = 8'h00;
      sRd = 1'b0;
      sLast = 1'b1;
      case (op_q)
         LCR_OP_CUR_WR: begin
            sAddr = step_q == 2'd0 ? `LCR_CUR_WR_LO : `LCR_CUR_WR_HI;
            sData = step_q == 2'd0 ? arg_q[7:0] : {1'b0, arg_q[14:8]};
            sLast = step_q == 2'd1;
         end
         LCR_OP_CUR_RD: begin
            sAddr = step_q == 2'd0 ? `LCR_CUR_RD_LO : `LCR_CUR_RD_HI;
            sRd = 1'b1;
            sLast = step_q == 2'd1;
         end
         LCR_OP_MEM_WR: begin
            sAddr = `LCR_MEM_DATA;
            sData = arg_q[7:0];
         end
         LCR_OP_MEM_RD: begin
            sAddr = `LCR_MEM_DATA;
            sRd = 1'b1;
         end
         LCR_OP_DEPTH: begin
            case (step_q)
               2'd0: begin
                  sAddr = `LCR_DEPTH;
                  sData = {6'h00, arg_q[1:0]};
               end
               2'd1: begin
                  sAddr = `LCR_CHAR_SIZE;
                  sData = `LCR_CHAR_SIZE_VAL;
               end
               default: sAddr = `LCR_PIX_SCROLL;
            endcase
            sLast = arg_q[1:0] == 2'b00 || step_q == 2'd2;
         end
         LCR_OP_PANEL: begin
            sAddr = `LCR_PANEL;
            sData = arg_q[7:0] & ~(8'h01 << `LCR_PNL_RSV);
         end
         LCR_OP_PLL: begin
            case (step_q)
               2'd0: begin
                  sAddr = `LCR_PLL_DIV;
                  sData = arg_q[7:0];
               end
               2'd1: begin
                  sAddr = `LCR_PLL_FILT;
                  sData = {filt, arg_q[11:8]};
               end
               default: begin
                  sAddr = `LCR_PLL_VCO;
                  sData = {1'b0, arg_q[13:12], vcoRange(fvco)};
               end
            endcase
            sLast = step_q == 2'd2;
         end
         LCR_OP_ID: begin
            sAddr = `LCR_PROD_ID;
            sRd = 1'b1;
         end
         default: sLast = 1'b1;
      endcase
   end

   // sequencer
   always_comb begin
      state_d = state_q;
      op_d = op_q;
      arg_d = arg_q;
      step_d = step_q;
      err_d = err_q;
      panelOn_d = panelOn_q;
      addr_d = addr_q;
      wd_d = 8'h00;
      wr_d = 1'b0;
      rd_d = 1'b0;
      // read data stand the cycle after the strobe; capture them then
      rdPend_d = rd_q;
      capHi_d = rd_q && addr_q == `LCR_CUR_RD_HI;
      rsp_d = rsp_q;
      if (rdPend_q) begin
         if (capHi_q) rsp_d[15:8] = bus.rdData;
         else rsp_d[7:0] = bus.rdData;
      end
      case (state_q)
         LCR_IDLE: begin
            if (cmdValid) begin
               op_d = cmdOp;
               arg_d = cmdData;
               step_d = 2'd0;
               err_d = 1'b0;
               rsp_d = 16'h0000;
               if (cmdOp == LCR_OP_DEPTH && textMode)
                  arg_d[1:0] = 2'b00;
               state_d = LCR_RUN;
               if ((cmdOp == LCR_OP_PANEL || cmdOp == LCR_OP_PLL) &&
                  displayOn && panelOn_q) begin
                  err_d = 1'b1;
                  state_d = LCR_DONE;
               end
            end
         end
         LCR_RUN: begin
            if (op_q == LCR_OP_PLL && bad) begin
               err_d = 1'b1;
               state_d = LCR_DONE;
            end else begin
               addr_d = sAddr;
               wd_d = sRd ? 8'h00 : sData;
               wr_d = !sRd;
               rd_d = sRd;
               if (op_q == LCR_OP_PANEL)
                  panelOn_d = sData[`LCR_PNL_EN];
               step_d = step_q + 2'd1;
               if (sLast) state_d = LCR_DONE;
            end
         end
         LCR_DONE: begin
            if (!rdPend_q && !rd_q) state_d = LCR_IDLE;
         end
         default: state_d = LCR_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= LCR_IDLE;
         op_q <= LCR_OP_ID;
         arg_q <= 16'h0000;
         step_q <= 2'd0;
         err_q <= 1'b0;
         panelOn_q <= 1'b0;
         addr_q <= 16'h0000;
         wd_q <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         rdPend_q <= 1'b0;
         capHi_q <= 1'b0;
         rsp_q <= 16'h0000;
         busy_q <= 1'b0;
         rspValid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         arg_q <= arg_d;
         step_q <= step_d;
         err_q <= err_d;
         panelOn_q <= panelOn_d;
         addr_q <= addr_d;
         wd_q <= wd_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         rdPend_q <= rdPend_d;
         capHi_q <= capHi_d;
         rsp_q <= rsp_d;
         busy_q <= state_d != LCR_IDLE;
         rspValid_q <= state_q == LCR_DONE && state_d == LCR_IDLE;
      end
   end

   assign bus.addr = addr_q;
   assign bus.wrData = wd_q;
   assign bus.wrStb = wr_q;
   assign bus.rdStb = rd_q;
   assign busy = busy_q;
   assign rspValid = rspValid_q;
   assign rspErr = err_q;
   assign rspData = rsp_q;
endmodule : lcr_host

// File: verification/lcr_bus_monitor.sv
`timescale 1ns/1ps
`include "lcr_defines.svh"
module lcr_bus_monitor #(
   parameter logic [7:0] PRODUCT_ID = 8'h3c // arbitrary value
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [15:0] addr,
   input wire logic [7:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   input wire logic [7:0] rdData
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   ///////////////////////////////////////////////////////////////////////////
   // strobe exclusion and read answers of the device
   a_strobe_excl: assert property (!(wrStb && rdStb))
      else $error("both strobes high");
   a_rd_idle: assert property (!$past(rdStb) |-> rdData == 8'h00)
      else $error("read data outside answer cycle");
   a_id_fixed: assert property (rdStb && addr == `LCR_PROD_ID |=>
      rdData == PRODUCT_ID) else $error("product code wrong");
   a_cur_hi_top: assert property (rdStb && addr == `LCR_CUR_RD_HI |=>
      !rdData[7]) else $error("cursor high byte bit 7 set");
   ///////////////////////////////////////////////////////////////////////////
   // order and content of host reads and writes
   a_cur_rd_pair: assert property (rdStb && addr == `LCR_CUR_RD_LO |->
      ##[1:4] (rdStb && addr == `LCR_CUR_RD_HI))
      else $error("cursor high byte not read");
   a_cur_wr_pair: assert property (wrStb && addr == `LCR_CUR_WR_LO |->
      ##[1:4] (wrStb && addr == `LCR_CUR_WR_HI))
      else $error("cursor high byte not written");
   a_depth_code: assert property (wrStb && addr == `LCR_DEPTH |->
      wrData[1:0] != 2'h3) else $error("reserved depth code");
   a_depth_size: assert property (wrStb && addr == `LCR_DEPTH &&
      wrData[1:0] != 2'h0 |-> ##[1:4] (wrStb && addr == `LCR_CHAR_SIZE
      && wrData == `LCR_CHAR_SIZE_VAL)) else $error("char size not set");
   a_vco_rsv: assert property (wrStb && addr == `LCR_PLL_VCO |->
      !wrData[`LCR_VCO_RSV]) else $error("vco reserved bit set");
   a_panel_rsv: assert property (wrStb && addr == `LCR_PANEL |->
      !wrData[`LCR_PNL_RSV]) else $error("panel reserved bit set");
endmodule : lcr_bus_monitor

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import lcr_pkg::*;
;
   typedef struct {lcr_op_type op; logic [15:0] d; int k; logic [15:0] e;
      logic er;} lcr_row_type;
   logic clk, rst_b, cmdValid, textMode, displayOn;
   logic busy, rspValid, rspErr, pixelClockOut, frameSyncOut, lineSyncOut;
   logic dataEnableOut, scalerNearest, panelEnabled;
   logic [15:0] cmdData, rspData;
   lcr_op_type cmdOp;
   logic [5:0] panelDataOut;
   logic [4:0] inputDivideRatio, pllMultiplier, outputDivideRatio;
   logic [4:0] vcoRangeField;
   logic [3:0] vcoFactor, pllFilterField;
   int err_total = 0;
   int tests_run = 0;
   int n;
   logic [7:0] depthSeen;
   lcr_row_type rows[16] = '{
      '{LCR_OP_ID, 16'h0000, 1, 16'h003c, 1'b0},
      '{LCR_OP_CUR_WR, 16'h1234, 0, 16'h0000, 1'b0},
      '{LCR_OP_CUR_RD, 16'h0000, 2, 16'h1234, 1'b0},
      '{LCR_OP_MEM_WR, 16'h005a, 0, 16'h0000, 1'b0},
      '{LCR_OP_MEM_WR, 16'h00c3, 0, 16'h0000, 1'b0},
      '{LCR_OP_CUR_RD, 16'h0000, 2, 16'h1236, 1'b0},
      '{LCR_OP_CUR_WR, 16'h1234, 0, 16'h0000, 1'b0},
      '{LCR_OP_MEM_RD, 16'h0000, 1, 16'h005a, 1'b0},
      '{LCR_OP_MEM_RD, 16'h0000, 1, 16'h00c3, 1'b0},
      '{LCR_OP_CUR_WR, 16'h7fff, 0, 16'h0000, 1'b0},
      '{LCR_OP_MEM_WR, 16'h0011, 0, 16'h0000, 1'b0},
      '{LCR_OP_CUR_RD, 16'h0000, 2, 16'h0000, 1'b0},
      '{LCR_OP_DEPTH, 16'h0001, 0, 16'h0000, 1'b0},
      '{LCR_OP_PLL, 16'h133c, 0, 16'h0000, 1'b1},
      '{LCR_OP_PLL, 16'h1331, 0, 16'h0000, 1'b0},
      '{LCR_OP_PANEL, 16'h00ec, 0, 16'h0000, 1'b0}};
   ///////////////////////////////////////////////////////////////////////////
   // two ends joined by the bus, monitor beside it
   lcr_bus_if u_lcr_bus_if();
   lcr_host u_lcr_host(.clk(clk), .rst_b(rst_b), .bus(u_lcr_bus_if),
      .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdData(cmdData),
      .textMode(textMode), .displayOn(displayOn), .busy(busy),
      .rspValid(rspValid), .rspErr(rspErr), .rspData(rspData));
   lcr_device #(.PRODUCT_ID(8'h3c), .HACT(8), .VACT(4), .HTOT(12),
      .VTOT(6)) u_lcr_device(.clk(clk), .rst_b(rst_b),
      .bus(u_lcr_bus_if), .pixelClockOut(pixelClockOut),
      .frameSyncOut(frameSyncOut), .lineSyncOut(lineSyncOut),
      .dataEnableOut(dataEnableOut), .panelDataOut(panelDataOut),
      .inputDivideRatio(inputDivideRatio), .pllMultiplier(pllMultiplier),
      .vcoFactor(vcoFactor), .outputDivideRatio(outputDivideRatio),
      .pllFilterField(pllFilterField), .vcoRangeField(vcoRangeField),
      .scalerNearest(scalerNearest), .panelEnabled(panelEnabled));
   lcr_bus_monitor u_lcr_bus_monitor(.clk(clk),
      .rst_b(rst_b), .addr(u_lcr_bus_if.addr),
      .wrData(u_lcr_bus_if.wrData), .wrStb(u_lcr_bus_if.wrStb),
      .rdStb(u_lcr_bus_if.rdStb), .rdData(u_lcr_bus_if.rdData));
   // last depth code the host put on the bus
   always @(posedge clk) begin
      if (u_lcr_bus_if.wrStb && u_lcr_bus_if.addr == 16'h8020) begin
         depthSeen <= u_lcr_bus_if.wrData;
      end
   end
   ///////////////////////////////////////////////////////////////////////////
   // compare, command and closing tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic run_cmd(input lcr_op_type op, input logic [15:0] d);
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdOp <= op;
      cmdData <= d;
      @(posedge clk);
      cmdValid <= 1'b0;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         #1;
         if (rspValid === 1'b1) break;
      end
      check({15'h0000, rspValid}, 16'h0001);
   endtask : run_cmd
   task automatic results();
      $display("errors %0d of %0d checks", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results
   ///////////////////////////////////////////////////////////////////////////
   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #(25 * 20000);
      err_total++;
      results();
   end
   ///////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst_b = 1'b0;
      cmdValid = 1'b0;
      cmdOp = LCR_OP_ID;
      cmdData = 16'h0000;
      textMode = 1'b0;
      displayOn = 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      // reset values of the pll and panel decode
      check({inputDivideRatio, pllMultiplier, vcoFactor}, 16'h04a2);
      check({11'h000, outputDivideRatio}, 16'h000f);
      check({pllFilterField, vcoRangeField}, 16'h0124);
      check({14'h0000, scalerNearest, frameSyncOut}, 16'h0003);
      foreach (rows[i]) begin
         run_cmd(rows[i].op, rows[i].d);
         check({15'h0000, rspErr}, {15'h0000, rows[i].er});
         if (rows[i].k == 2) check(rspData, rows[i].e);
         if (rows[i].k == 1) check({8'h00, rspData[7:0]}, rows[i].e);
         if (i == 12) check({8'h00, depthSeen}, 16'h0001);
         if (i == 14) begin
            @(posedge clk);
            #1;
            check({inputDivideRatio, pllMultiplier, vcoFactor},
               16'h0442);
            check({11'h000, outputDivideRatio}, 16'h0004);
            check({pllFilterField, vcoRangeField}, 16'h00e3);
         end
      end
      // panel off with high polarity: syncs rest low
      repeat (2) @(posedge clk);
      #1;
      check({6'h00, pixelClockOut, panelDataOut, frameSyncOut, lineSyncOut,
         dataEnableOut}, 16'h0000);
      check({14'h0000, scalerNearest, panelEnabled}, 16'h0002);
      run_cmd(LCR_OP_PANEL, 16'h00e5);
      for (n = 0; n < 1000 && frameSyncOut !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      check({15'h0000, frameSyncOut}, 16'h0001);
      check({15'h0000, panelEnabled}, 16'h0001);
      // panel live: panel and PLL changes are refused, text mode forces depth 00
      displayOn <= 1'b1;
      run_cmd(LCR_OP_PANEL, 16'h00e4);
      check({15'h0000, rspErr}, 16'h0001);
      run_cmd(LCR_OP_PLL, 16'h1331);
      check({15'h0000, rspErr}, 16'h0001);
      check({15'h0000, panelEnabled}, 16'h0001);
      textMode <= 1'b1;
      run_cmd(LCR_OP_DEPTH, 16'h0002);
      check({8'h00, depthSeen}, 16'h0000);
      run_cmd(LCR_OP_CUR_RD, 16'h0000);
      check(rspData, 16'h0000);
      results();
   end
endmodule : tb_top
